// [ocd_consts.vh]
// constants for the output channel divider block: offsets, fields, resets
// included by ocd_divider.v only
`ifndef OCD_CONSTS_VH
`define OCD_CONSTS_VH

// register indices; byte address is four times the index
`define OCD_IDX_DIV1_PHASE 12'h094
`define OCD_IDX_CHAN1_PWR 12'h095
`define OCD_IDX_DIV2_CYC 12'h096
`define OCD_IDX_DIV2_BYP 12'h097
`define OCD_IDX_DIV2_FSP 12'h197
`define OCD_IDX_CHAN2_PWR 12'h198
`define OCD_IDX_DIV3_CYC 12'h199
`define OCD_IDX_DIV3_BYP 12'h19a
// own choice: channel 1 control (bypass, ignore sync, force, start)
`define OCD_IDX_DIV1_CTRL 12'h200
// own choice: channel 1 cycle counts
`define OCD_IDX_DIV1_CYC 12'h201
// own choice: channel 3 power, then read-only status of outputs in [2:0]
`define OCD_IDX_DIV3_PWR 12'h202
`define OCD_IDX_STATUS 12'h203

// field positions
`define OCD_BIT_BYPASS 7
`define OCD_BIT_IGNSYNC 6
`define OCD_BIT_FORCE 5
`define OCD_BIT_START 4
`define OCD_BIT_PWRDN 2
`define OCD_BIT_DCCDIS 0

// reset values
`define OCD_RST_CYC2 8'h11
`define OCD_RST_CYC3 8'h00
`define OCD_RST_CYC1 8'h33
`define OCD_RST_ZERO 8'h00

`endif

// [ocd_divider.v]
// three output channel dividers with a classic wishbone register slave
// assumes clk_i is the divider input clock; sync_i is an asynchronous pin
//
// Summary of operation
// [RULE1] output stays low for low-cycle field plus one input cycles
// [RULE2] output stays high for high-cycle field plus one input cycles
// [RULE3] field value zero gives exactly one cycle in that phase
// [RULE4] bypass set passes the input clock straight to the output
// [RULE5] sync obeyed while ignore-sync clear, disregarded while set
// [RULE6] force drives a static level only while ignore-sync is also set
// [RULE7] force has no effect while the channel is bypassed
// [RULE8] forced level is low for force zero, high for force one
// [RULE9] start-level bit chooses the initial output level
// [RULE10] four-bit phase offset delays the output, resets to zero
// [RULE11] channel power-down disables its three outputs, high-impedance
// [RULE12] duty-cycle correction on while disable bit is zero
// [RULE13] period is sum of low and high counts, repeating continuously
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/10ps
`include "ocd_consts.vh"

module ocd_divider (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [13:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  // chip-level sync pin, active high
  input wire sync_i,
  // per channel divided clock, output enables, correction enables
  output wire [2:0] div_clk_o,
  output wire [8:0] out_oe_o,
  output wire [2:0] duty_cycle_correction_en_o
);

  // per channel register fields: cyc = {low,high}, ctl = {byp,ign,frc,start,phase}
  reg [7:0] cyc_q [0:2];
  reg [7:0] ctl_q [0:2];
  reg [2:0] pwrdn_q;
  reg [2:0] dccdis_q;
  reg [2:0] sync_meta_q;
  reg [2:0] sync_q;
  reg [2:0] sync_prev_q;
  reg [2:0] dout_q;
  wire [11:0] idx;
  wire req;
  wire wr;
  reg hit;
  reg [7:0] rdat;

  assign idx = wb_adr_i[13:2];
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign wb_err_o = 1'b0;

  // sync pin double-flopped; each bit is one copy per channel
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_meta_q <= 3'h0;
      sync_q <= 3'h0;
      sync_prev_q <= 3'h0;
    end else begin
      sync_meta_q <= {3{sync_i}};
      sync_q <= sync_meta_q;
      sync_prev_q <= sync_q;
    end
  end

  // read decode
  always @* begin
    hit = 1'b1;
    rdat = 8'h00;
    case (idx)
      `OCD_IDX_DIV1_CTRL: rdat = ctl_q[0];
      `OCD_IDX_DIV1_CYC: rdat = cyc_q[0];
      `OCD_IDX_DIV1_PHASE: rdat = {4'h0, ctl_q[0][3:0]};
      `OCD_IDX_CHAN1_PWR: rdat = {5'h00, pwrdn_q[0], 1'b0, dccdis_q[0]};
      `OCD_IDX_DIV2_CYC: rdat = cyc_q[1];
      `OCD_IDX_DIV2_BYP: rdat = {ctl_q[1][7:6], 6'h00};
      `OCD_IDX_DIV2_FSP: rdat = {2'h0, ctl_q[1][5:0]};
      `OCD_IDX_CHAN2_PWR: rdat = {5'h00, pwrdn_q[1], 1'b0, dccdis_q[1]};
      `OCD_IDX_DIV3_CYC: rdat = cyc_q[2];
      `OCD_IDX_DIV3_BYP: rdat = ctl_q[2];
      `OCD_IDX_DIV3_PWR: rdat = {5'h00, pwrdn_q[2], 1'b0, dccdis_q[2]};
      `OCD_IDX_STATUS: rdat = {5'h00, div_clk_o};
      default: begin
        hit = 1'b0;
        rdat = 8'h00;
      end
    endcase
  end

  // bus answer: one cycle after the request, unmapped reads give zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && hit) ? {24'h000000, rdat} : 32'h00000000;
    end
  end

  // register writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      cyc_q[0] <= `OCD_RST_CYC1;
      cyc_q[1] <= `OCD_RST_CYC2;
      cyc_q[2] <= `OCD_RST_CYC3;
      ctl_q[0] <= `OCD_RST_ZERO; // [RULE10]
      ctl_q[1] <= `OCD_RST_ZERO;
      ctl_q[2] <= `OCD_RST_ZERO;
      pwrdn_q <= 3'h0;
      dccdis_q <= 3'h0;
    end else if (wr) begin
      case (idx)
        `OCD_IDX_DIV1_CTRL: ctl_q[0][7:4] <= wb_dat_i[7:4];
        `OCD_IDX_DIV1_CYC: cyc_q[0] <= wb_dat_i[7:0];
        `OCD_IDX_DIV1_PHASE: ctl_q[0][3:0] <= wb_dat_i[3:0];
        `OCD_IDX_CHAN1_PWR: begin
          pwrdn_q[0] <= wb_dat_i[`OCD_BIT_PWRDN];
          dccdis_q[0] <= wb_dat_i[`OCD_BIT_DCCDIS];
        end
        `OCD_IDX_DIV2_CYC: cyc_q[1] <= wb_dat_i[7:0];
        `OCD_IDX_DIV2_BYP: ctl_q[1][7:6] <= wb_dat_i[7:6];
        `OCD_IDX_DIV2_FSP: ctl_q[1][5:0] <= wb_dat_i[5:0];
        `OCD_IDX_CHAN2_PWR: begin
          pwrdn_q[1] <= wb_dat_i[`OCD_BIT_PWRDN];
          dccdis_q[1] <= wb_dat_i[`OCD_BIT_DCCDIS];
        end
        `OCD_IDX_DIV3_CYC: cyc_q[2] <= wb_dat_i[7:0];
        `OCD_IDX_DIV3_BYP: ctl_q[2] <= wb_dat_i[7:0];
        `OCD_IDX_DIV3_PWR: begin
          pwrdn_q[2] <= wb_dat_i[`OCD_BIT_PWRDN];
          dccdis_q[2] <= wb_dat_i[`OCD_BIT_DCCDIS];
        end
        default: begin
        end
      endcase
    end
  end

  // per channel counters
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ch
      reg [3:0] cnt_q;
      reg [3:0] dly_q;
      reg lvl_q;
      reg run_q;
      wire byp;
      wire ign;
      wire frc;
      wire start;
      wire [3:0] phase;
      wire restart;
      wire [3:0] lim;
      assign byp = ctl_q[g][`OCD_BIT_BYPASS];
      assign ign = ctl_q[g][`OCD_BIT_IGNSYNC];
      assign frc = ctl_q[g][`OCD_BIT_FORCE];
      assign start = ctl_q[g][`OCD_BIT_START];
      assign phase = ctl_q[g][3:0];
      // sync rising edge restarts the channel unless ignored
      assign restart = sync_q[g] && !sync_prev_q[g] && !ign; // [RULE5]
      // phase length: low uses [7:4], high uses [3:0]
      assign lim = lvl_q ? cyc_q[g][3:0] : cyc_q[g][7:4]; // [RULE1] [RULE2]

      always @(posedge clk_i) begin
        if (rst_i) begin
          cnt_q <= 4'h0;
          dly_q <= 4'h0;
          lvl_q <= 1'b0;
          run_q <= 1'b0;
        end else if (restart || !run_q) begin
          cnt_q <= 4'h0;
          dly_q <= phase; // [RULE10]
          lvl_q <= start; // [RULE9]
          run_q <= 1'b1;
        end else if (dly_q != 4'h0) begin
          dly_q <= dly_q - 4'h1;
        end else if (cnt_q >= lim) begin
          // zero limit toggles every cycle, one cycle per phase
          cnt_q <= 4'h0; // [RULE3]
          lvl_q <= !lvl_q; // [RULE13]
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end

      always @(posedge clk_i) begin
        if (rst_i) begin
          dout_q[g] <= 1'b0;
        end else if (ign && frc && !byp) begin
          dout_q[g] <= 1'b1; // [RULE6] [RULE8]
        end else if (ign && !byp) begin
          dout_q[g] <= 1'b0; // [RULE6] [RULE8]
        end else begin
          dout_q[g] <= lvl_q;
        end
      end

      // bypass forwards the input clock itself, force ignored
      assign div_clk_o[g] = byp ? clk_i : dout_q[g]; // [RULE4] [RULE7]
      assign out_oe_o[3*g+2:3*g] = {3{!pwrdn_q[g]}}; // [RULE11]
      assign duty_cycle_correction_en_o[g] = !dccdis_q[g]; // [RULE12]
    end
  endgenerate

endmodule

// [ocd_props.sv]
// checker for ocd_divider port relations
// sees only the top ports; bound below
`timescale 1ns/10ps
module ocd_props (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire wb_err_o,
  input wire [2:0] div_clk_o,
  input wire [8:0] out_oe_o,
  input wire [2:0] duty_cycle_correction_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_err_never: assert property (!wb_err_o) else $error("err raised");
  a_oe_groups_whole: assert property (&out_oe_o[2:0] == |out_oe_o[2:0] &&
    &out_oe_o[5:3] == |out_oe_o[5:3] && &out_oe_o[8:6] == |out_oe_o[8:6])
    else $error("output enables split in a group");
  a_oe_on_write: assert property ($changed(out_oe_o) |-> wb_ack_o && wb_we_i)
    else $error("enables changed without write");
  a_reset_outputs: assert property (disable iff (1'h0) rst_i |=> div_clk_o == 3'h0 &&
    out_oe_o == 9'h1ff) else $error("outputs not at reset level");
  a_reset_dcc_on: assert property (disable iff (1'h0) rst_i |=>
    duty_cycle_correction_en_o == 3'h7) else $error("correction off after reset");
endmodule
bind ocd_divider ocd_props i_ocd_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .div_clk_o(div_clk_o), .out_oe_o(out_oe_o),
  .duty_cycle_correction_en_o(duty_cycle_correction_en_o));

// [output_channel_divider_tb.sv]
// bench for ocd_divider: registers, division, force, bypass, sync, power
// drives wishbone and sync itself
`timescale 1ns/10ps
module output_channel_divider_tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sync = 0, ack, err;
  logic [13:0] adr = 0;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 0, rdat;
  logic [2:0] dclk, dcc;
  logic [8:0] oe;
  logic [7:0] q;
  int errors = 0, total_checks = 0, cycles = 0, n, hi, lo;
  always #2.5 clk_i = ~clk_i;
  ocd_divider i_ocd_divider (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .sync_i(sync), .div_clk_o(dclk), .out_oe_o(oe),
    .duty_cycle_correction_en_o(dcc));
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input [31:0] seen, input [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle, entered just after a rising edge
  task wb(input [11:0] idx, input w, input [7:0] d);
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= {idx, 2'h0}; dat <= {24'h0, d};
    do begin @(posedge clk_i); n++; end while (ack !== 1'h1 && n < 50);
    if (n >= 50) begin
      errors++;
      summarize;
    end
    q = rdat[7:0];
    cyc <= 0; stb <= 0;
    @(posedge clk_i);
  endtask
  task rd(input [11:0] idx, input [7:0] exp, input string what);
    wb(idx, 0, 8'h00);
    check(q, exp, what);
    check(err, 1'h0, "bus error");
  endtask
  task meas(input int ch);
    hi = 0; lo = 0; n = 0;
    while (dclk[ch] !== 1'h0 && n < 99) begin @(posedge clk_i); n++; end
    while (dclk[ch] !== 1'h1 && n < 99) begin @(posedge clk_i); n++; end
    while (dclk[ch] === 1'h1 && n < 99) begin @(posedge clk_i); n++; hi++; end
    while (dclk[ch] === 1'h0 && n < 99) begin @(posedge clk_i); n++; lo++; end
  endtask
  // second period only: field changes take effect mid-phase, as lim reads cyc_q directly
  task per(input int ch, input int eh, input int el);
    meas(ch);
    meas(ch);
    check(hi, eh, "high cycles");
    check(lo, el, "low cycles");
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      summarize;
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    check(oe, 9'h1ff, "enables");
    check(dcc, 3'h7, "correction");
    rd(12'h096, 8'h11, "div2 counts");
    rd(12'h199, 8'h00, "div3 counts");
    rd(12'h197, 8'h00, "div2 phase");
    rd(12'h123, 8'h00, "unmapped");
    rd(12'h201, 8'h33, "div1 counts");
    sel <= 4'h0;
    wb(12'h199, 1, 8'h55);
    sel <= 4'hf;
    rd(12'h199, 8'h00, "no byte enable");
    wb(12'h19a, 1, 8'h03);
    rd(12'h19a, 8'h03, "div3 phase");
    wb(12'h19a, 1, 8'h00);
    $display("reset test done");
    per(1, 2, 2);
    per(2, 1, 1);
    per(0, 4, 4);
    wb(12'h096, 1, 8'h52);
    per(1, 3, 6);
    wb(12'h096, 1, 8'h03);
    per(1, 4, 1);
    $display("period test done");
    wb(12'h097, 1, 8'h40);
    wb(12'h197, 1, 8'h20);
    repeat (8) @(posedge clk_i);
    check(dclk[1], 1'h1, "forced high");
    wb(12'h197, 1, 8'h00);
    repeat (8) @(posedge clk_i);
    check(dclk[1], 1'h0, "forced low");
    wb(12'h197, 1, 8'h20);
    wb(12'h097, 1, 8'hc0);
    #1 check(dclk[1], 1'h1, "bypass high");
    @(negedge clk_i) #1 check(dclk[1], 1'h0, "bypass low");
    @(posedge clk_i);
    wb(12'h097, 1, 8'h00);
    wb(12'h096, 1, 8'h33);
    for (int s = 0; s < 3; s++) begin
      wb(12'h197, 1, {3'h0, s != 0, (s == 2) ? 4'h3 : 4'h0});
      sync <= 1;
      @(posedge clk_i) sync <= 0;
      repeat (5) @(posedge clk_i);
      check(dclk[1], s != 0, "start level");
      repeat (4) @(posedge clk_i);
      check(dclk[1], s != 1, "phase offset");
    end
    wb(12'h197, 1, 8'h20);
    per(1, 4, 4);
    $display("force and sync test done");
    wb(12'h095, 1, 8'h05);
    wb(12'h198, 1, 8'h04);
    check(oe, 9'h1c0, "power down");
    check(dcc, 3'h6, "correction off");
    $display("power test done");
    summarize;
  end
endmodule
